// ===== design/fsrel_pkg.sv
// package of register offsets, keys and reset values for the safety output release block
package fsrel_pkg;

	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] FSREL_OFS_WIN_DUR = 8'h00;
	localparam logic [7:0] FSREL_OFS_WIN_NOT = 8'h04;
	localparam logic [7:0] FSREL_OFS_ANSWER = 8'h08;
	localparam logic [7:0] FSREL_OFS_STATE = 8'h0c;
	localparam logic [7:0] FSREL_OFS_RELEASE = 8'h10;
	localparam logic [7:0] FSREL_OFS_STATUS = 8'h14;

	// ************************************************
	// field positions and keys
	// ************************************************
	// five-bit period sits in the top bits, so a zero there turns windowing off
	localparam int FSREL_PERIOD_LSB = 11;
	localparam int FSREL_PERIOD_W = 5;
	localparam int FSREL_DBG_EXIT_BIT = 14;
	// bits [7:4] of the window word are not implemented and skip the complement check
	localparam logic [15:0] FSREL_WIN_IMPL_MASK = 16'hff0f;
	localparam logic [15:0] FSREL_GOOD_ANSWER = 16'h5ab2;
	localparam logic [15:0] FSREL_RELEASE_KEY = 16'hb2a5;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [15:0] FSREL_WIN_DUR_RST = 16'h0000;
	localparam logic [15:0] FSREL_WIN_NOT_RST = 16'hffff;
	localparam logic [3:0] FSREL_FAULT_CNT_RST = 4'h6;

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {
		FSREL_ST_INIT = 2'b00,
		FSREL_ST_DEBUG = 2'b01,
		FSREL_ST_NORMAL = 2'b11
	} fsrel_state_t;

	typedef enum logic [1:0] {
		FSREL_RESP_OKAY = 2'b00,
		FSREL_RESP_SLVERR = 2'b10
	} fsrel_resp_t;

endpackage : fsrel_pkg

// ===== design/fsrel_win_check.sv
// window configuration check: complement pair validation and windowing decode
`timescale 1ns/1ps
`default_nettype none
module fsrel_win_check (
	input wire logic [15:0] win_dur,
	input wire logic [15:0] win_not,
	output logic cfg_valid,
	output logic windowing_on
);
	import fsrel_pkg::*;

	// configuration counts only while the implemented bits of the complement match
	assign cfg_valid = (((win_dur ^ ~win_not) & FSREL_WIN_IMPL_MASK) == 16'h0000);
	// zero period means windowing disabled
	assign windowing_on = (win_dur[FSREL_PERIOD_LSB +: FSREL_PERIOD_W] != '0);

endmodule : fsrel_win_check
`default_nettype wire

// ===== design/fsrel_pin_sync.sv
// three-stage synchroniser for an asynchronous pin level
`timescale 1ns/1ps
`default_nettype none
module fsrel_pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_in,
	output logic level_out
);
	import fsrel_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} fsrel_sync_t;

	fsrel_sync_t sync_q, sync_d;

	always_comb begin
		sync_d = sync_q;
		sync_d.s1 = pin_in;
		sync_d.s2 = sync_q.s1;
		sync_d.s3 = sync_q.s2;
		// change counts once second and third stage agree
		if (sync_q.s2 == sync_q.s3) begin
			sync_d.lvl = sync_q.s3;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_q <= '0;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign level_out = sync_q.lvl;

endmodule : fsrel_pin_sync
`default_nettype wire

// ===== design/fsrel_top.sv
// safety output release sequencer with axi4-lite register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module fsrel_top #(
	parameter logic [3:0] FAULT_CNT_INIT = fsrel_pkg::FSREL_FAULT_CNT_RST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic debug_entry_pin,
	input wire logic otp_windowing_en,
	output logic safety_output_pin,
	output logic debug_mode,
	output logic windowing_active
);
	import fsrel_pkg::*;

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] win_dur;
		logic [15:0] win_not;
		fsrel_state_t st;
		logic [3:0] fault_cnt;
		logic released;
		logic strap_done;
		logic win_on;
		logic awrdy;
		logic wrdy;
		logic arrdy;
		logic dbg;
	} fsrel_regs_t;

	fsrel_regs_t r_q, r_d;

	logic dbg_level;
	logic cfg_valid;
	logic period_nonzero;
	logic wr_fire;
	logic [15:0] wr_val;

	fsrel_pin_sync fsrel_pin_sync_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(debug_entry_pin),
		.level_out(dbg_level)
	);

	fsrel_win_check fsrel_win_check_i (
		.win_dur(r_q.win_dur),
		.win_not(r_q.win_not),
		.cfg_valid(cfg_valid),
		.windowing_on(period_nonzero)
	);

	// merges byte lanes of the low half-word into an old value
	function automatic logic [15:0] fsrel_merge(input logic [15:0] old, input logic [15:0] nv,
		input logic [1:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = nv[7:0];
		end
		if (strb[1]) begin
			res[15:8] = nv[15:8];
		end
		return res;
	endfunction : fsrel_merge

	function automatic logic fsrel_mapped(input logic [7:0] a);
		return (a == FSREL_OFS_WIN_DUR) || (a == FSREL_OFS_WIN_NOT) || (a == FSREL_OFS_ANSWER)
			|| (a == FSREL_OFS_STATE) || (a == FSREL_OFS_RELEASE) || (a == FSREL_OFS_STATUS);
	endfunction : fsrel_mapped

	assign wr_fire = r_q.aw_got && r_q.w_got && !r_q.bvalid;
	assign wr_val = fsrel_merge(16'h0000, r_q.w_data, r_q.w_strb);

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		r_d = r_q;
		// write address and data are taken independently, one write in flight
		if (s_axil_awvalid && s_axil_awready) begin
			r_d.aw_got = 1'b1;
			r_d.aw_addr = s_axil_awaddr;
		end
		if (s_axil_wvalid && s_axil_wready) begin
			r_d.w_got = 1'b1;
			r_d.w_data = s_axil_wdata[15:0];
			r_d.w_strb = s_axil_wstrb[1:0];
		end
		if (r_q.bvalid && s_axil_bready) begin
			r_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			r_d.aw_got = 1'b0;
			r_d.w_got = 1'b0;
			r_d.bvalid = 1'b1;
			r_d.bresp = FSREL_RESP_OKAY;
			// each write is one sequence step, applied on its own
			if (r_q.aw_addr == FSREL_OFS_WIN_DUR) begin
				r_d.win_dur = fsrel_merge(r_q.win_dur, r_q.w_data, r_q.w_strb);
			end else if (r_q.aw_addr == FSREL_OFS_WIN_NOT) begin
				r_d.win_not = fsrel_merge(r_q.win_not, r_q.w_data, r_q.w_strb);
			end else if (r_q.aw_addr == FSREL_OFS_ANSWER) begin
				if (wr_val == FSREL_GOOD_ANSWER) begin
					if (r_q.st == FSREL_ST_INIT) begin
						r_d.st = FSREL_ST_DEBUG;
					end else if (r_q.st == FSREL_ST_NORMAL && r_q.fault_cnt != 4'h0) begin
						r_d.fault_cnt = r_q.fault_cnt - 4'h1;
					end
				end
			end else if (r_q.aw_addr == FSREL_OFS_STATE) begin
				if (wr_val[FSREL_DBG_EXIT_BIT] && r_q.st == FSREL_ST_DEBUG) begin
					r_d.st = FSREL_ST_NORMAL;
				end
			end else if (r_q.aw_addr == FSREL_OFS_RELEASE) begin
				// release needs normal mode, cleared counter and otp windowing
				if (wr_val == FSREL_RELEASE_KEY && r_q.st == FSREL_ST_NORMAL
					&& r_q.fault_cnt == 4'h0 && otp_windowing_en) begin
					r_d.released = 1'b1;
				end
			end else if (r_q.aw_addr == FSREL_OFS_STATUS) begin
				r_d.bresp = FSREL_RESP_SLVERR;
			end else begin
				r_d.bresp = FSREL_RESP_SLVERR;
			end
		end
		// first cycle after reset forces the state to init; the debug pin level is not sampled here
		if (!r_q.strap_done) begin
			r_d.strap_done = 1'b1;
			r_d.st = FSREL_ST_INIT;
		end
		// windowing only in normal mode with a valid nonzero period
		r_d.win_on = (r_q.st == FSREL_ST_NORMAL) && cfg_valid && period_nonzero && !dbg_level;
		if (r_q.rvalid && s_axil_rready) begin
			r_d.rvalid = 1'b0;
		end
		if (s_axil_arvalid && s_axil_arready) begin
			r_d.rvalid = 1'b1;
			r_d.rresp = FSREL_RESP_OKAY;
			r_d.rdata = 32'h0000_0000;
			if (s_axil_araddr == FSREL_OFS_WIN_DUR) begin
				r_d.rdata[15:0] = r_q.win_dur;
			end else if (s_axil_araddr == FSREL_OFS_WIN_NOT) begin
				r_d.rdata[15:0] = r_q.win_not;
			end else if (s_axil_araddr == FSREL_OFS_STATE) begin
				r_d.rdata[FSREL_DBG_EXIT_BIT] = (r_q.st == FSREL_ST_NORMAL);
				r_d.rdata[1:0] = r_q.st;
			end else if (s_axil_araddr == FSREL_OFS_STATUS) begin
				r_d.rdata[3:0] = r_q.fault_cnt;
				r_d.rdata[5:4] = r_q.st;
				r_d.rdata[6] = r_q.released;
				r_d.rdata[7] = cfg_valid;
				r_d.rdata[8] = r_q.win_on;
			end else if (!fsrel_mapped(s_axil_araddr)) begin
				r_d.rresp = FSREL_RESP_SLVERR;
			end
		end
		// ready and mode flags come straight from flip-flops
		r_d.awrdy = !r_d.aw_got && !r_d.bvalid;
		r_d.wrdy = !r_d.w_got && !r_d.bvalid;
		r_d.arrdy = !r_d.rvalid;
		r_d.dbg = (r_d.st != FSREL_ST_NORMAL);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_q <= '{aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_data: 16'h0000, w_strb: 2'b00,
				bvalid: 1'b0, bresp: 2'b00, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'b00,
				win_dur: FSREL_WIN_DUR_RST, win_not: FSREL_WIN_NOT_RST, st: FSREL_ST_INIT,
				fault_cnt: FAULT_CNT_INIT, released: 1'b0, strap_done: 1'b0, win_on: 1'b0,
				awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, dbg: 1'b1};
		end else begin
			r_q <= r_d;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign s_axil_awready = r_q.awrdy;
	assign s_axil_wready = r_q.wrdy;
	assign s_axil_bvalid = r_q.bvalid;
	assign s_axil_bresp = r_q.bresp;
	assign s_axil_arready = r_q.arrdy;
	assign s_axil_rvalid = r_q.rvalid;
	assign s_axil_rdata = r_q.rdata;
	assign s_axil_rresp = r_q.rresp;
	assign safety_output_pin = r_q.released;
	assign debug_mode = r_q.dbg;
	assign windowing_active = r_q.win_on;

	// ************************************************
	// assertions
	// ************************************************
	property p_pin_low_in_debug;
		@(posedge aclk) disable iff (!aresetn) (r_q.st != FSREL_ST_NORMAL) |-> !safety_output_pin;
	endproperty
	a_pin_low_in_debug: assert property (p_pin_low_in_debug) else $error("pin released in debug");

	property p_release;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && r_q.aw_addr == FSREL_OFS_RELEASE && wr_val == FSREL_RELEASE_KEY
			&& r_q.st == FSREL_ST_NORMAL && r_q.fault_cnt == 4'h0 && otp_windowing_en)
			|=> safety_output_pin;
	endproperty
	a_release: assert property (p_release) else $error("release key ignored");

	property p_release_needs_otp;
		@(posedge aclk) disable iff (!aresetn) ($rose(safety_output_pin)) |-> $past(otp_windowing_en);
	endproperty
	a_release_needs_otp: assert property (p_release_needs_otp) else $error("release without otp");

	property p_init_close;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && r_q.aw_addr == FSREL_OFS_ANSWER && wr_val == FSREL_GOOD_ANSWER
			&& r_q.st == FSREL_ST_INIT && r_q.strap_done) |=> (r_q.st == FSREL_ST_DEBUG);
	endproperty
	a_init_close: assert property (p_init_close) else $error("init not closed");

	property p_dbg_exit;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && r_q.aw_addr == FSREL_OFS_STATE && wr_val[FSREL_DBG_EXIT_BIT]
			&& r_q.st == FSREL_ST_DEBUG) |=> !debug_mode;
	endproperty
	a_dbg_exit: assert property (p_dbg_exit) else $error("debug not exited");

	property p_count_down;
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && r_q.aw_addr == FSREL_OFS_ANSWER && wr_val == FSREL_GOOD_ANSWER
			&& r_q.st == FSREL_ST_NORMAL && r_q.fault_cnt != 4'h0)
			|=> (r_q.fault_cnt == $past(r_q.fault_cnt) - 4'h1);
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter not decremented");

	property p_win_debug;
		@(posedge aclk) disable iff (!aresetn) debug_mode [*2] |-> !windowing_active;
	endproperty
	a_win_debug: assert property (p_win_debug) else $error("windowing in debug");

	property p_win_zero;
		@(posedge aclk) disable iff (!aresetn)
		(cfg_valid && !period_nonzero) [*2] |-> !windowing_active;
	endproperty
	a_win_zero: assert property (p_win_zero) else $error("zero period windowing");

	property p_win_cmp;
		@(posedge aclk) disable iff (!aresetn) !cfg_valid [*2] |-> !windowing_active;
	endproperty
	a_win_cmp: assert property (p_win_cmp) else $error("invalid pair accepted");

	property p_one_write;
		@(posedge aclk) disable iff (!aresetn) wr_fire |=> !wr_fire;
	endproperty
	a_one_write: assert property (p_one_write) else $error("two steps in one");

	c_release: cover property (@(posedge aclk) disable iff (!aresetn) $rose(safety_output_pin));
	c_dbg_exit: cover property (@(posedge aclk) disable iff (!aresetn) $fell(debug_mode));
	c_cnt_zero: cover property (@(posedge aclk) disable iff (!aresetn) $changed(r_q.fault_cnt)
		&& r_q.fault_cnt == 4'h0);
	c_win_on: cover property (@(posedge aclk) disable iff (!aresetn) $rose(windowing_active));
	c_init_close: cover property (@(posedge aclk) disable iff (!aresetn) $changed(r_q.st)
		&& r_q.st == FSREL_ST_DEBUG);

endmodule : fsrel_top
`default_nettype wire

// ===== verif/fsrel_host.sv
// host model: axi4-lite register master that sends one whole step at a time
`timescale 1ns/1ps
`default_nettype none
module fsrel_host (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		wstrb = 4'hf;
		// response ready stays high, so back-to-back steps never drive it twice in one step
		bready = 1'b1;
		rready = 1'b1;
	end
	// a step ends at its response, so steps never overlap or reorder
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
	endtask : rd
endmodule : fsrel_host
`default_nettype wire

// ===== verif/test_fsrel_top.sv
// testbench for the safety output release sequencer
`timescale 1ns/1ps
`default_nettype none
module test_fsrel_top;
	import fsrel_pkg::*;
	localparam logic [3:0] NCNT = 4'h2;
	localparam logic [1:0] OK = FSREL_RESP_OKAY;
	localparam logic [1:0] ER = FSREL_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic dbg_pin, otp_en, pin, dbg_mode, win_act;
	logic [34:0] eq[$];
	logic [34:0] e;
	logic [31:0] bad;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2 aclk = ~aclk;
	fsrel_top #(.FAULT_CNT_INIT(NCNT)) fsrel_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
		.debug_entry_pin(dbg_pin), .otp_windowing_en(otp_en), .safety_output_pin(pin),
		.debug_mode(dbg_mode), .windowing_active(win_act));
	fsrel_host fsrel_host_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
		.rready(rready));
	// ************************************************
	// checking
	// ************************************************
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (!ok) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
		if (aresetn === 1'b1 && ((bvalid && bready) || (rvalid && rready))) begin
			e = eq.pop_front();
			if (bvalid) chk(bresp === e[33:32], "write response");
			else chk(rresp === e[33:32] && (e[34] || rdata === e[31:0]), "read result");
		end
	end
	// ************************************************
	// stimulus helpers
	// ************************************************
	function automatic logic [34:0] st(input logic [3:0] c, input fsrel_state_t s, input logic rl,
		input logic wa);
		return {3'b000, 23'h0, wa, 1'b1, rl, s, c};
	endfunction : st
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		eq.push_back({1'b1, r, 32'h0});
		fsrel_host_i.wr(a, d);
	endtask : w
	task automatic r(input logic [7:0] a, input logic [34:0] x);
		eq.push_back(x);
		fsrel_host_i.rd(a);
	endtask : r
	task automatic pin_is(input logic v);
		@(posedge aclk);
		#1;
		chk(pin === v, "safety output level");
	endtask : pin_is
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		void'($urandom(32'h55d6cf2e));
		aresetn = 1'b0;
		dbg_pin = 1'b0;
		otp_en = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_INIT, 1'b0, 1'b0));
		r(8'h18, {1'b1, ER, 32'h0});
		w(FSREL_OFS_STATUS, 32'h0, ER);
		w(FSREL_OFS_WIN_DUR, 32'h020b, OK);
		w(FSREL_OFS_WIN_NOT, 32'hfd04, OK);
		r(FSREL_OFS_WIN_DUR, {3'b000, 32'h020b});
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_INIT, 1'b0, 1'b0));
		w(FSREL_OFS_ANSWER, 32'h5ab2, OK);
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_DEBUG, 1'b0, 1'b0));
		w(FSREL_OFS_ANSWER, 32'h5ab2, OK);
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_DEBUG, 1'b0, 1'b0));
		w(FSREL_OFS_RELEASE, 32'hb2a5, OK);
		pin_is(1'b0);
		chk(dbg_mode === 1'b1, "debug mode held");
		w(FSREL_OFS_STATE, 32'h4000, OK);
		r(FSREL_OFS_STATE, {3'b000, 32'h4003});
		chk(dbg_mode === 1'b0, "debug mode left");
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_NORMAL, 1'b0, 1'b0));
		chk(win_act === 1'b0, "windowing off with zero period");
		bad = $urandom();
		if (bad[15:0] == FSREL_GOOD_ANSWER) bad[0] = ~bad[0];
		w(FSREL_OFS_ANSWER, bad, OK);
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_NORMAL, 1'b0, 1'b0));
		for (int i = 0; i <= NCNT; i++) begin
			w(FSREL_OFS_ANSWER, 32'h5ab2, OK);
			r(FSREL_OFS_STATUS, st((i < NCNT) ? NCNT - 4'(i) - 4'h1 : 4'h0, FSREL_ST_NORMAL, 1'b0, 1'b0));
		end
		otp_en <= 1'b0;
		w(FSREL_OFS_RELEASE, 32'hb2a5, OK);
		pin_is(1'b0);
		otp_en <= 1'b1;
		w(FSREL_OFS_RELEASE, 32'hb2a4, OK);
		pin_is(1'b0);
		w(FSREL_OFS_RELEASE, 32'hb2a5, OK);
		pin_is(1'b1);
		r(FSREL_OFS_STATUS, st(4'h0, FSREL_ST_NORMAL, 1'b1, 1'b0));
		w(FSREL_OFS_WIN_DUR, 32'h0800, OK);
		w(FSREL_OFS_WIN_NOT, 32'hf7ff, OK);
		r(FSREL_OFS_STATUS, st(4'h0, FSREL_ST_NORMAL, 1'b1, 1'b1));
		chk(win_act === 1'b1, "windowing on with nonzero period");
		dbg_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		r(FSREL_OFS_STATUS, st(4'h0, FSREL_ST_NORMAL, 1'b1, 1'b0));
		chk(win_act === 1'b0, "windowing held off by debug pin");
		dbg_pin <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		pin_is(1'b0);
		r(FSREL_OFS_STATUS, st(NCNT, FSREL_ST_INIT, 1'b0, 1'b0));
		print_verdict();
	end
endmodule : test_fsrel_top
`default_nettype wire
